// File: common/gpio_params.svh
// Register indices, field positions, reset values and role codes of the GPIO block
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// Printed register indices; byte address on the bus is four times the index
`define FIRST_LEVEL_IDX 16'h0C00
`define FIRST_ROLES_IDX 16'h0C02
`define SECOND_LEVEL_IDX 16'h0C04
`define SECOND_ROLES_IDX 16'h0C06

// Pins per port and field positions inside a register word
`define PINS_PER_PORT 4
`define LEVEL_LSB 4
`define LEVEL_MSB 7
`define ROLES_LSB 8
`define ROLES_MSB 15
`define ROLE_BITS 2

// Reset values
`define LEVEL_RESET 4'h0
`define ROLES_RESET 8'h00
`define READ_IDLE 32'h0000_0000

// Role field encodings
`define ROLE_CODE_INPUT 2'h0
`define ROLE_CODE_ALT 2'h1
`define ROLE_CODE_OUTPUT 2'h2
`define ROLE_CODE_RSVD 2'h3

// Pins for which alternate function one exists (bit 0 is pin 4)
`define FIRST_ALT_PINS 4'hE
`define SECOND_ALT_PINS 4'h8

`endif

// File: common/gpio_pkg.sv
// Types shared by the GPIO block: bus carriers, pad bundles and pin roles
package gpio_pkg;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [15:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avs_rsp_t;

  // Four pad drivers: level to drive and driver enable
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] enable;
  } nibble_drive_t;

  // Decoded role of one pin
  typedef enum logic [1:0] {
    ROLE_INPUT,
    ROLE_ALT,
    ROLE_OUTPUT,
    ROLE_RSVD
  } pin_role_t;

  // Bus handshake state
  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

endpackage

// File: rtl/pin_sync.sv
// Two-flop synchroniser for the four pad levels of one port
`timescale 1ns/1ps
`include "gpio_params.svh"

module pin_sync
  import gpio_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [3:0] pins_in,
  output logic [3:0] level_out
);

  logic [3:0] meta_ff;
  logic [3:0] stable_ff;
  logic [3:0] nxt_meta;
  logic [3:0] nxt_stable;

  // First stage feeds only the second stage
  always_comb begin
    nxt_meta = meta_ff;
    nxt_stable = stable_ff;
    if (ce_in) begin
      nxt_meta = pins_in;
      nxt_stable = meta_ff;
    end
  end

  // Clears to low so reads after reset see a known level
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_ff <= `LEVEL_RESET;
      stable_ff <= `LEVEL_RESET;
    end else begin
      meta_ff <= nxt_meta;
      stable_ff <= nxt_stable;
    end
  end

  assign level_out = stable_ff;

endmodule

// File: rtl/dual_nibble_gpio_port.sv
// GPIO for pins 7..4 of two ports, shared with alternate functions, on Avalon-MM
//
// Summary of operation
// - First-port pins 7..5 and second-port pin 7 are shared with an on-chip function; the role field picks who owns the pad.
// - The first port level register keeps pins 7..4 in bits 7-4, bits 3-0 and the upper byte unused.
// - A first-port input pin reads back as its sampled pad level, one meaning high.
// - A first-port output pin reads back as the stored register bit, not the pad.
// - A first-port output pin drives the written bit, one high and zero low.
// - The first port role register holds two bits per pin in bits 15-8, pin 4 in bits 9-8.
// - Role code 00 is input and the reset value, 01 alternate one, 10 output, 11 unused.
// - The second port level register keeps pins 7..4 in bits 7-4, bits 3-0 reading zero.
// - A second-port pin reads as its pad level as input and its stored bit as output.
// - A second-port output pin drives the written bit, one giving high.
// - The second port role register holds two bits per pin in the upper byte, lower byte unused.
// - Second-port role codes decode exactly as the first port's do.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "gpio_params.svh"

module dual_nibble_gpio_port
  import gpio_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire avs_req_t avs_req_in,
  output avs_rsp_t avs_rsp_out,
  input wire logic [3:0] first_port_pins_in,
  input wire logic [3:0] second_port_pins_in,
  input wire nibble_drive_t first_port_alt_in,
  input wire nibble_drive_t second_port_alt_in,
  output nibble_drive_t first_port_pads_out,
  output nibble_drive_t second_port_pads_out,
  output logic [3:0] first_port_alt_sense_out,
  output logic [3:0] second_port_alt_sense_out,
  output logic [3:0] first_port_alt_sel_out,
  output logic [3:0] second_port_alt_sel_out
);

  // Byte addresses: index shifted by two, bus words are 32 bits
  // Printed role offsets 0C02 and 0C06 are not word multiples, hence the index scaling
  localparam logic [15:0] FIRST_LEVEL_ADDR = 16'(`FIRST_LEVEL_IDX << 2);
  localparam logic [15:0] FIRST_ROLES_ADDR = 16'(`FIRST_ROLES_IDX << 2);
  localparam logic [15:0] SECOND_LEVEL_ADDR = 16'(`SECOND_LEVEL_IDX << 2);
  localparam logic [15:0] SECOND_ROLES_ADDR = 16'(`SECOND_ROLES_IDX << 2);

  // Set where the pin has an alternate function; elsewhere that role is refused
  localparam logic [1:0][3:0] ALT_PINS = {`SECOND_ALT_PINS, `FIRST_ALT_PINS};

  // Role code to role; 11 is kept apart so it can be parked safely
  function automatic pin_role_t role_of(input logic [1:0] code);
    pin_role_t role;
    role = ROLE_RSVD;
    unique case (code)
      `ROLE_CODE_INPUT: role = ROLE_INPUT;
      `ROLE_CODE_ALT: role = ROLE_ALT;
      `ROLE_CODE_OUTPUT: role = ROLE_OUTPUT;
      `ROLE_CODE_RSVD: role = ROLE_RSVD;
    endcase
    return role;
  endfunction

  // Role field of pin i (pin 4 is i = 0) inside an eight-bit role byte
  function automatic pin_role_t pin_role(input logic [7:0] roles, input int unsigned i);
    logic [1:0] code;
    code = roles[2 * i +: `ROLE_BITS];
    return role_of(code);
  endfunction

  // Register select; a misaligned address never matches, as all targets are words
  function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] target);
    logic aligned;
    aligned = (addr[1:0] == 2'h0);
    return aligned && (addr == target);
  endfunction

  // Bus handshake state
  bus_state_t state_ff;
  bus_state_t nxt_state;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  // Register file: one level nibble and one role byte per port
  logic [1:0][3:0] level_ff;
  logic [1:0][3:0] nxt_level;
  logic [1:0][7:0] roles_ff;
  logic [1:0][7:0] nxt_roles;

  // Pad side state
  logic [1:0][3:0] pad_level_ff;
  logic [1:0][3:0] nxt_pad_level;
  logic [1:0][3:0] pad_enable_ff;
  logic [1:0][3:0] nxt_pad_enable;
  logic [1:0][3:0] alt_sel_ff;
  logic [1:0][3:0] nxt_alt_sel;

  // Combinational helpers; the vectors are nets, since each bit has its own driver
  wire logic [1:0][3:0] sensed;
  wire logic [1:0][3:0] readback;
  wire logic [1:0][3:0] alt_level;
  wire logic [1:0][3:0] alt_enable;
  wire logic [1:0] hit_level;
  wire logic [1:0] hit_roles;
  logic answer_now;
  logic wr_commit;
  logic level_lane;
  logic roles_lane;

  // Pad levels come from another domain, so each passes two flops
  pin_sync first_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .pins_in(first_port_pins_in),
    .level_out(sensed[0])
  );

  pin_sync second_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .pins_in(second_port_pins_in),
    .level_out(sensed[1])
  );

  // Alternate function drive, split per port
  assign alt_level[0] = first_port_alt_in.level;
  assign alt_level[1] = second_port_alt_in.level;
  assign alt_enable[0] = first_port_alt_in.enable;
  assign alt_enable[1] = second_port_alt_in.enable;

  // Address decode; misaligned or unmapped addresses hit nothing
  assign hit_level[0] = reg_hit(avs_req_in.address, FIRST_LEVEL_ADDR);
  assign hit_roles[0] = reg_hit(avs_req_in.address, FIRST_ROLES_ADDR);
  assign hit_level[1] = reg_hit(avs_req_in.address, SECOND_LEVEL_ADDR);
  assign hit_roles[1] = reg_hit(avs_req_in.address, SECOND_ROLES_ADDR);

  // Byte lanes: lane 0 carries levels, lane 1 roles, lanes 2 and 3 are ignored
  assign level_lane = avs_req_in.byteenable[0];
  assign roles_lane = avs_req_in.byteenable[1];

  // Answer counts only while enabled, so a frozen cycle also holds the master off
  assign answer_now = ce_in && (state_ff == BUS_ANSWER);

  // Write lands at the edge where waitrequest is seen low
  assign wr_commit = answer_now && avs_req_in.write;

  // Per pin readback: stored bit for outputs, pad level otherwise
  // Alternate-role pins also read the pad, as their function owns it
  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      for (genvar i = 0; i < `PINS_PER_PORT; i++) begin : g_pin
        assign readback[p][i] = (pin_role(roles_ff[p], i) == ROLE_OUTPUT) ?
          level_ff[p][i] : sensed[p][i];
      end
    end
  endgenerate

  // Bus handshake: one wait cycle, then the answer cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_rdata = rdata_ff;
    if (ce_in) begin
      unique case (state_ff)
        BUS_IDLE: begin
          if (avs_req_in.read || avs_req_in.write) begin
            nxt_state = BUS_ANSWER;
          end
          // Read word is caught here so it is a flop during the answer
          nxt_rdata = `READ_IDLE;
          if (avs_req_in.read) begin
            for (int p = 0; p < 2; p++) begin
              if (hit_level[p]) begin
                nxt_rdata[`LEVEL_MSB:`LEVEL_LSB] = readback[p];
              end
              if (hit_roles[p]) begin
                nxt_rdata[`ROLES_MSB:`ROLES_LSB] = roles_ff[p];
              end
            end
          end
        end
        BUS_ANSWER: begin
          // Request must drop before the next edge or it is taken again
          nxt_state = BUS_IDLE;
        end
      endcase
    end
  end

  // Bus state and captured read word, cleared so a stray sample sees zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_ff <= BUS_IDLE;
      rdata_ff <= `READ_IDLE;
    end else begin
      state_ff <= nxt_state;
      rdata_ff <= nxt_rdata;
    end
  end

  // Waitrequest is high except in an enabled answer cycle, also while idle
  assign avs_rsp_out.waitrequest = !answer_now;
  assign avs_rsp_out.readdata = rdata_ff;

  // Register writes with byte enables; lane 0 levels, lane 1 roles
  always_comb begin
    nxt_level = level_ff;
    nxt_roles = roles_ff;
    if (wr_commit) begin
      for (int p = 0; p < 2; p++) begin
        // Stored in any role so a later switch to output drives it
        if (hit_level[p] && level_lane) begin
          nxt_level[p] = avs_req_in.writedata[`LEVEL_MSB:`LEVEL_LSB];
        end
        // Role bits keep any code written, even one that parks the pad
        if (hit_roles[p] && roles_lane) begin
          nxt_roles[p] = avs_req_in.writedata[`ROLES_MSB:`ROLES_LSB];
        end
      end
    end
  end

  // Register file; levels reset low so a fresh output starts low
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      level_ff <= {2{`LEVEL_RESET}};
      roles_ff <= {2{`ROLES_RESET}};
    end else begin
      level_ff <= nxt_level;
      roles_ff <= nxt_roles;
    end
  end

  // Pad multiplexer: owner of each pad follows its role field
  always_comb begin
    nxt_pad_level = pad_level_ff;
    nxt_pad_enable = pad_enable_ff;
    nxt_alt_sel = alt_sel_ff;
    if (ce_in) begin
      for (int p = 0; p < 2; p++) begin
        for (int i = 0; i < `PINS_PER_PORT; i++) begin
          nxt_pad_level[p][i] = 1'b0;
          nxt_pad_enable[p][i] = 1'b0;
          nxt_alt_sel[p][i] = 1'b0;
          unique case (pin_role(roles_ff[p], i))
            ROLE_INPUT: begin
              nxt_pad_enable[p][i] = 1'b0;
            end
            ROLE_OUTPUT: begin
              nxt_pad_level[p][i] = level_ff[p][i];
              nxt_pad_enable[p][i] = 1'b1;
            end
            ROLE_ALT: begin
              // Pins with no alternate function stay released
              if (ALT_PINS[p][i]) begin
                nxt_pad_level[p][i] = alt_level[p][i];
                nxt_pad_enable[p][i] = alt_enable[p][i];
                nxt_alt_sel[p][i] = 1'b1;
              end
            end
            ROLE_RSVD: begin
              // Unused code parks the pad as an input
              nxt_pad_enable[p][i] = 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Registered pads cost one cycle but keep glitches off the board
  // Reset releases every pad before software sets a role
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pad_level_ff <= {2{`LEVEL_RESET}};
      pad_enable_ff <= {2{`LEVEL_RESET}};
      alt_sel_ff <= {2{`LEVEL_RESET}};
    end else begin
      pad_level_ff <= nxt_pad_level;
      pad_enable_ff <= nxt_pad_enable;
      alt_sel_ff <= nxt_alt_sel;
    end
  end

  // Outputs toward pads and toward the alternate functions
  // Sense shows the pad in every role; the function decides whether to use it
  assign first_port_pads_out.level = pad_level_ff[0];
  assign first_port_pads_out.enable = pad_enable_ff[0];
  assign second_port_pads_out.level = pad_level_ff[1];
  assign second_port_pads_out.enable = pad_enable_ff[1];
  assign first_port_alt_sense_out = sensed[0];
  assign second_port_alt_sense_out = sensed[1];
  assign first_port_alt_sel_out = alt_sel_ff[0];
  assign second_port_alt_sel_out = alt_sel_ff[1];

endmodule

// File: verif/board_pins.sv
// Board side of one nibble: pad wire resolved from chip driver and board level
`timescale 1ns/1ps
module board_pins
  import gpio_pkg::*;
(
  input wire nibble_drive_t pads_in,
  input wire logic [3:0] board_in,
  input wire logic [3:0] clamp_in,
  output logic [3:0] pins_out
);
  logic [3:0] drv;
  // A clamped pin models a board fault that overpowers the chip driver
  assign drv = pads_in.enable & ~clamp_in;
  assign pins_out = (pads_in.level & drv) | (board_in & ~drv);
endmodule

// File: verif/dual_nibble_gpio_port_properties.sv
// Port-level assertions for the two-nibble GPIO block
`timescale 1ns/1ps
module dual_nibble_gpio_port_properties
  import gpio_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire avs_req_t avs_req_in,
  input wire avs_rsp_t avs_rsp_out,
  input wire nibble_drive_t first_port_alt_in,
  input wire nibble_drive_t first_port_pads_out,
  input wire nibble_drive_t second_port_pads_out,
  input wire logic [3:0] first_port_alt_sel_out,
  input wire logic [3:0] second_port_alt_sel_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic req;
  logic wr;
  logic [15:0] adr;
  logic [31:0] rdd;
  // Short names for the bus fields
  assign req = avs_req_in.read | avs_req_in.write;
  assign wr = avs_rsp_out.waitrequest;
  assign adr = avs_req_in.address;
  assign rdd = avs_rsp_out.readdata;
  a_wait_answer: assert property (ce_in && wr && req |=> !wr)
    else $error("no answer one cycle after request");
  a_wait_single: assert property (!wr && ce_in |=> wr)
    else $error("answer held longer than one cycle");
  a_reset_idle: assert property (disable iff (1'b0) reset_in |=> wr &&
    first_port_pads_out.enable == 4'h0 && second_port_pads_out.enable == 4'h0 &&
    first_port_alt_sel_out == 4'h0) else $error("pads not released by reset");
  a_pin_four: assert property (!first_port_alt_sel_out[0])
    else $error("first port pin four handed to alternate function");
  a_second_alt: assert property (second_port_alt_sel_out[2:0] == 3'h0)
    else $error("second port pins 6..4 handed to alternate function");
  // Alternate owner drives the pad one edge after it asks
  a_alt_follow: assert property ($past(ce_in) |->
    (first_port_pads_out & {2{first_port_alt_sel_out}}) ==
    ($past(first_port_alt_in) & {2{first_port_alt_sel_out}}))
    else $error("alternate pins not driven by their function");
  a_level_rsvd: assert property (!wr && avs_req_in.read &&
    (adr == 16'h3000 || adr == 16'h3010) |-> rdd[31:8] == 24'h0 && rdd[3:0] == 4'h0)
    else $error("reserved level bits read nonzero");
  a_role_rsvd: assert property (!wr && avs_req_in.read &&
    (adr == 16'h3008 || adr == 16'h3018) |-> rdd[31:16] == 16'h0 && rdd[7:0] == 8'h0)
    else $error("reserved role bits read nonzero");
endmodule

bind dual_nibble_gpio_port dual_nibble_gpio_port_properties chk_i (
  .clk_in(clk_in),
  .reset_in(reset_in),
  .ce_in(ce_in),
  .avs_req_in(avs_req_in),
  .avs_rsp_out(avs_rsp_out),
  .first_port_alt_in(first_port_alt_in),
  .first_port_pads_out(first_port_pads_out),
  .second_port_pads_out(second_port_pads_out),
  .first_port_alt_sel_out(first_port_alt_sel_out),
  .second_port_alt_sel_out(second_port_alt_sel_out)
);

// File: verif/tb_dual_nibble_gpio_port.sv
// Self-checking bench for the two-nibble GPIO block
`timescale 1ns/1ps
module tb_dual_nibble_gpio_port
  import gpio_pkg::*;
;
  localparam logic [15:0] al1 = 16'h3000, ar1 = 16'h3008, al2 = 16'h3010, ar2 = 16'h3018;
  logic clk, rst, ce;
  avs_req_t req;
  avs_rsp_t rsp;
  logic [3:0] b1, b2, c1, pin1, pin2, sen1, sen2, sel1, sel2;
  nibble_drive_t alt1, alt2, p1, p2;
  logic [31:0] q;
  int n_fail, samples_checked;
  dual_nibble_gpio_port DUT (.clk_in(clk), .reset_in(rst), .ce_in(ce), .avs_req_in(req),
    .avs_rsp_out(rsp), .first_port_pins_in(pin1), .second_port_pins_in(pin2),
    .first_port_alt_in(alt1), .second_port_alt_in(alt2), .first_port_pads_out(p1),
    .second_port_pads_out(p2), .first_port_alt_sense_out(sen1),
    .second_port_alt_sense_out(sen2), .first_port_alt_sel_out(sel1),
    .second_port_alt_sel_out(sel2));
  board_pins board1 (.pads_in(p1), .board_in(b1), .clamp_in(c1), .pins_out(pin1));
  board_pins board2 (.pads_in(p2), .board_in(b2), .clamp_in(4'h0), .pins_out(pin2));
  // Free-running bus clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pad view: driven levels only, then enables
  function automatic logic [31:0] pv(input nibble_drive_t p);
    return {24'h0, p.level & p.enable, p.enable};
  endfunction
  // One bus cycle; request held until waitrequest is seen low
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, !w, w, d, 4'hF};
    // No cycle count assumed; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Covers pad register lag and the two-flop pin synchroniser
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the hundred or so cycles of the sequence
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    req = '0;
    {b1, b2, c1} = 12'h000;
    alt1 = '0;
    alt2 = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(al1, 32'h0);
    rd(ar1, 32'h0);
    rd(al2, 32'h0);
    rd(ar2, 32'h0);
    b1 <= 4'hA;
    b2 <= 4'h5;
    settle;
    rd(al1, 32'hA0);
    rd(al2, 32'h50);
    chk(pv(p1), 32'h0);
    wr(ar1, 32'hAA00);
    settle;
    chk(pv(p1), 32'h0F);
    wr(al1, 32'h50);
    settle;
    chk(pv(p1), 32'h5F);
    // Board overpowers the pads, so stored and sensed levels differ
    @(posedge clk);
    c1 <= 4'hF;
    settle;
    rd(al1, 32'h50);
    chk({28'h0, sen1}, 32'hA);
    c1 <= 4'h0;
    wr(ar2, 32'h8000);
    wr(al2, 32'hF0);
    settle;
    chk(pv(p2), 32'h88);
    rd(al2, 32'hD0);
    chk({28'h0, sen2}, 32'hD);
    alt1 <= '{4'hC, 4'hF};
    alt2 <= '{4'h0, 4'hF};
    wr(ar1, 32'h5400);
    wr(ar2, 32'h4000);
    settle;
    chk({28'h0, sel1}, 32'hE);
    chk(pv(p1), 32'hCE);
    chk({28'h0, sel2}, 32'h8);
    chk(pv(p2), 32'h08);
    wr(ar1, 32'h8000);
    settle;
    chk(pv(p1), 32'h08);
    rd(ar1, 32'h8000);
    wr(16'h3004, 32'hFFFF);
    rd(16'h3004, 32'h0);
    wr(al2, 32'hFFFF_FFFF);
    rd(al2, 32'h50);
    // Enable low must freeze pads and synchronisers alike
    ce <= 1'b0;
    b2 <= 4'hA;
    alt2 <= '{4'hF, 4'hF};
    settle;
    chk({28'h0, sen2}, 32'h5);
    chk(pv(p2), 32'h08);
    @(posedge clk);
    ce <= 1'b1;
    settle;
    chk({28'h0, sen2}, 32'hA);
    chk(pv(p2), 32'h88);
    print_verdict;
  end
endmodule
